// File: hw/ccpu_pkg.sv
// package for the capture/compare/pwm unit: offsets, fields, modes, types
// assumes an APB slave with 32-bit data, one register per aligned word
//
// Contract
// (RL1) value held as separately accessible low and high bytes
// (RL2) special trigger match resets timebase, starts conversion if enabled
// (RL3) pin routed to one of two port pins by a configuration bit
// (RL4) capture/compare use timebase count; pwm uses period timer
// (RL5) mode 0000 disables and resets unit, here only output latch and prescaler clear; 11xx selects pwm
// (RL6) qualifying pin event copies full timebase count into value pair
// (RL7) event is falling, rising, every 4th or every 16th rising edge
// (RL8) every capture sets the unit interrupt flag, bit 2
// (RL9) software clears the interrupt flag; hardware never clears it
// (RL10) a newer capture overwrites an unread older one
// (RL11) pin driven as output can trigger capture by port writes
// (RL12) software should make the pin an input for capture
// (RL13) software runs timebase synchronously while capturing
// (RL14) changing capture mode may set the flag spuriously
// (RL15) software keeps enable clear and clears flag after mode change
// (RL16) prescaler counter cleared when off, not capturing, or reset
// (RL17) switching prescale settings keeps counter and may set flag
// (RL18) software writes zero before a new prescale setting
// (RL19) pwm duty is low byte then control bits 5:4
// (RL20) compare match sets flag and drives pin high, low or unchanged
// (RL21) special trigger reset does not set timebase overflow flag
// (RL22) capture modes 0100 fall, 0101 rise, 0110 4th, 0111 16th
// (RL23) compare modes 1000 high, 1001 low, 1010 irq, 1011 trigger
package ccpu_pkg;

  // ****************************************
  // register map, word index times four
  // ****************************************
  localparam logic [7:0] CCPU_IDX_VAL_LO  = 8'h15;
  localparam logic [7:0] CCPU_IDX_VAL_HI  = 8'h16;
  localparam logic [7:0] CCPU_IDX_CTRL    = 8'h17;
  localparam logic [7:0] CCPU_IDX_IRQ     = 8'h0C;
  localparam logic [7:0] CCPU_IDX_IEN     = 8'h8C;
  localparam logic [7:0] CCPU_IDX_STATUS  = 8'h20;
  localparam int         CCPU_FLAG_BIT    = 2;
  localparam int         CCPU_DUTY_LSB    = 4;
  localparam logic [7:0] CCPU_CTRL_RST    = 8'h00;
  localparam logic [7:0] CCPU_CTRL_MASK   = 8'h3F;
  localparam logic [7:0] CCPU_IRQ_MASK    = 8'h04;
  localparam logic [3:0] CCPU_PRE_RST     = 4'h0;
  localparam logic [3:0] CCPU_PRE_4       = 4'h3;
  localparam logic [3:0] CCPU_PRE_16      = 4'hF;

  // ****************************************
  // mode encodings
  // ****************************************
  localparam logic [3:0] CCPU_M_OFF   = 4'h0;
  // (RL22) capture encodings
  localparam logic [3:0] CCPU_M_FALL  = 4'h4;
  localparam logic [3:0] CCPU_M_RISE  = 4'h5;
  localparam logic [3:0] CCPU_M_RISE4 = 4'h6;
  localparam logic [3:0] CCPU_M_RISE16 = 4'h7;
  // (RL23) compare encodings
  localparam logic [3:0] CCPU_M_CMPHI = 4'h8;
  localparam logic [3:0] CCPU_M_CMPLO = 4'h9;
  localparam logic [3:0] CCPU_M_CMPSW = 4'hA;
  localparam logic [3:0] CCPU_M_TRIG  = 4'hB;

  // unit operating class
  typedef enum logic [1:0] {
    CCPU_OFF,
    CCPU_CAP,
    CCPU_CMP,
    CCPU_PWM
  } ccpu_class_t;

  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ccpu_apb_req_t;

  // apb answer bundle
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ccpu_apb_rsp_t;

  // all state of the unit
  typedef struct packed {
    logic [7:0]  val_lo;
    logic [7:0]  val_hi;
    logic [7:0]  ctrl;
    logic        flag;
    logic        ien;
    logic [3:0]  pre;
    logic [1:0]  duty_lo;
    logic        pin_out;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_d;
    logic        match_d;
    logic        tb_clr;
    logic        adc_go;
    logic [31:0] rdata;
    logic        rvalid;
  } ccpu_state_t;

endpackage

// File: hw/ccpu_unit.sv
// capture/compare/pwm unit with an apb register port
// assumes timebase and period timer live outside and are on pclk;
// the pin input arrives from outside and is synchronised here
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps

module ccpu_unit
(
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // register bus
  input  wire ccpu_pkg::ccpu_apb_req_t apb_req,
  output ccpu_pkg::ccpu_apb_rsp_t      apb_rsp,
  // timers
  input  wire logic [15:0]             timebase_count,
  input  wire logic [7:0]              period_timer_count,
  input  wire logic [1:0]              period_timer_sub,
  input  wire logic                    period_timer_wrap,
  input  wire logic                    adc_enabled,
  output logic                         timebase_reset,
  output logic                         adc_start,
  // pin and routing
  input  wire logic                    pin_route_select,
  input  wire logic                    pin_in,
  input  wire logic                    port_pin_is_output,
  output logic                         port_pin_two_out,
  output logic                         port_pin_three_out,
  output logic                         unit_drives_pin,
  // interrupt flag as seen by the system
  output logic                         unit_irq_flag,
  output logic                         unit_irq_request
);
  import ccpu_pkg::*;

  ccpu_state_t s_r;
  ccpu_state_t s_nxt;

  // ****************************************
  // helpers
  // ****************************************
  function automatic ccpu_class_t mode_class(input logic [3:0] m);
    if (m == CCPU_M_OFF)
      return CCPU_OFF;
    else if (m[3:2] == 2'b11)
      return CCPU_PWM;
    else if (m[3])
      return CCPU_CMP;
    else if (m[2])
      return CCPU_CAP;
    else
      return CCPU_OFF;
  endfunction

  logic [3:0]  mode;
  ccpu_class_t cls;
  logic        rise;
  logic        fall;
  logic        cap_evt;
  logic        match;
  logic        wr;
  logic        rd;
  logic [7:0]  widx;
  logic [7:0]  wb;

  assign mode = s_r.ctrl[3:0];
  assign cls  = mode_class(mode);
  // edges from the synchronised pin; an output pin loops back, so a
  // port write can also cause a capture
  // (RL11) loopback capture path
  assign rise = s_r.pin_s2 & ~s_r.pin_d;
  assign fall = ~s_r.pin_s2 & s_r.pin_d;
  assign wr   = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd   = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign widx = apb_req.paddr[9:2];
  assign wb   = apb_req.pwdata[7:0];
  // (RL4) compare against timebase
  assign match = (cls == CCPU_CMP) &&
                 ({s_r.val_hi, s_r.val_lo} == timebase_count);

  // (RL7) event selection by prescale
  always_comb
  begin
    cap_evt = 1'b0;
    case (mode)
      CCPU_M_FALL:   cap_evt = fall;
      CCPU_M_RISE:   cap_evt = rise;
      CCPU_M_RISE4:  cap_evt = rise && (s_r.pre[1:0] == CCPU_PRE_4[1:0]);
      CCPU_M_RISE16: cap_evt = rise && (s_r.pre == CCPU_PRE_16);
      default:       cap_evt = 1'b0;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.pin_s1 = pin_in;
    s_nxt.pin_s2 = s_r.pin_s1;
    s_nxt.pin_d  = s_r.pin_s2;
    s_nxt.tb_clr = 1'b0;
    s_nxt.adc_go = 1'b0;
    s_nxt.rvalid = 1'b0;
    s_nxt.match_d = match;

    // (RL16) prescaler cleared unless capturing
    if (cls != CCPU_CAP)
      s_nxt.pre = CCPU_PRE_RST;
    else if (rise && (mode == CCPU_M_RISE4 || mode == CCPU_M_RISE16))
      s_nxt.pre = s_r.pre + 4'h1;

    // (RL1) byte-wide register writes; high byte read-only in pwm
    if (wr && widx == CCPU_IDX_VAL_LO)
      s_nxt.val_lo = wb;
    if (wr && widx == CCPU_IDX_VAL_HI && cls != CCPU_PWM)
      s_nxt.val_hi = wb;
    if (wr && widx == CCPU_IDX_IEN)
      s_nxt.ien = wb[CCPU_FLAG_BIT];
    // (RL9) software clear of the flag
    if (wr && widx == CCPU_IDX_IRQ)
      s_nxt.flag = wb[CCPU_FLAG_BIT];
    if (wr && widx == CCPU_IDX_CTRL)
    begin
      s_nxt.ctrl = wb & CCPU_CTRL_MASK;
      // (RL14) mode change may flag spuriously
      // (RL17) prescale switch keeps count, may flag
      if (cls == CCPU_CAP && mode_class(wb[3:0]) == CCPU_CAP &&
          wb[3:0] != mode && s_r.pin_s2)
        s_nxt.flag = 1'b1;
    end

    // (RL6) copy timebase on event
    // (RL10) newest capture overwrites
    if (cls == CCPU_CAP && cap_evt)
    begin
      s_nxt.val_lo = timebase_count[7:0];
      s_nxt.val_hi = timebase_count[15:8];
      // (RL8) capture sets the flag, wins over clear
      s_nxt.flag   = 1'b1;
    end

    // (RL20) compare match actions, first cycle of match only
    if (match && !s_r.match_d)
    begin
      s_nxt.flag = 1'b1;
      case (mode)
        CCPU_M_CMPHI: s_nxt.pin_out = 1'b1;
        CCPU_M_CMPLO: s_nxt.pin_out = 1'b0;
        // (RL2) special trigger, conversion gated by enable
        // (RL21) only a reset pulse; no overflow flag raised here
        CCPU_M_TRIG:
        begin
          s_nxt.tb_clr = 1'b1;
          s_nxt.adc_go = adc_enabled;
        end
        default: s_nxt.pin_out = s_r.pin_out;
      endcase
    end

    // (RL19) pwm: latch duty at period wrap, set pin unless duty is zero, clear on match
    if (cls == CCPU_PWM)
    begin
      if (period_timer_wrap)
      begin
        s_nxt.val_hi  = s_r.val_lo;
        s_nxt.duty_lo = s_r.ctrl[CCPU_DUTY_LSB +: 2];
        s_nxt.pin_out = ({s_r.val_lo, s_r.ctrl[CCPU_DUTY_LSB +: 2]}
                         != 10'h000);
      end
      else if ({period_timer_count, period_timer_sub} ==
               {s_r.val_hi, s_r.duty_lo})
        s_nxt.pin_out = 1'b0;
    end

    // (RL5) zero mode write clears the output latch; value pair and flag keep their state; kept last
    // so a match or period wrap in the same cycle cannot set it again
    if (wr && widx == CCPU_IDX_CTRL && wb[3:0] == CCPU_M_OFF)
      s_nxt.pin_out = 1'b0;

    // read data captured in setup phase, presented in access phase
    if (rd)
    begin
      s_nxt.rvalid = 1'b1;
      case (widx)
        CCPU_IDX_VAL_LO: s_nxt.rdata = {24'h000000, s_r.val_lo};
        CCPU_IDX_VAL_HI: s_nxt.rdata = {24'h000000, s_r.val_hi};
        CCPU_IDX_CTRL:   s_nxt.rdata = {24'h000000, s_r.ctrl};
        CCPU_IDX_IRQ:
          s_nxt.rdata = {29'h0000000, s_r.flag, 2'b00};
        CCPU_IDX_IEN:
          s_nxt.rdata = {29'h0000000, s_r.ien, 2'b00};
        CCPU_IDX_STATUS:
          s_nxt.rdata = {27'h000000, s_r.pre, s_r.pin_out};
        default:         s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // unmapped address: error answer
  logic mapped;
  assign mapped = widx == CCPU_IDX_VAL_LO || widx == CCPU_IDX_VAL_HI ||
                  widx == CCPU_IDX_CTRL || widx == CCPU_IDX_IRQ ||
                  widx == CCPU_IDX_IEN || widx == CCPU_IDX_STATUS;

  // ****************************************
  // outputs
  // ****************************************
  // one driver for the whole answer bundle; no wait states inserted
  assign apb_rsp = '{pready:  1'b1,
                     pslverr: apb_req.psel & apb_req.penable & ~mapped,
                     prdata:  s_r.rdata};
  assign timebase_reset  = s_r.tb_clr;
  assign adc_start       = s_r.adc_go;
  assign unit_irq_flag   = s_r.flag;
  assign unit_irq_request = s_r.flag & s_r.ien;
  // (RL3) route output to one of two port pins
  assign port_pin_two_out   = ~pin_route_select & s_r.pin_out;
  assign port_pin_three_out = pin_route_select & s_r.pin_out;
  // compare and pwm own the pin, unless it is not set as an output
  assign unit_drives_pin = port_pin_is_output &&
                           (cls == CCPU_CMP || cls == CCPU_PWM);

  // ****************************************
  // checks
  // ****************************************
  // capture loads value and flag one edge later
  cap_load_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    (cls == CCPU_CAP && cap_evt) |=>
      ({s_r.val_hi, s_r.val_lo} == $past(timebase_count) && s_r.flag))
    else $error("capture did not load timebase");

  // flag never falls without a write to the flag register
  flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    $fell(s_r.flag) |-> $past(wr && widx == CCPU_IDX_IRQ))
    else $error("flag cleared by hardware");

  // prescaler empty outside capture
  pre_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RL16
    (cls != CCPU_CAP) |=> (s_r.pre == CCPU_PRE_RST || cls == CCPU_CAP))
    else $error("prescaler not cleared");

  // trigger pulse only in trigger mode
  trig_mode_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    s_r.tb_clr |-> $past(mode == CCPU_M_TRIG && match))
    else $error("trigger outside trigger mode");

  // conversion start only with converter enabled
  adc_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    s_r.adc_go |-> s_r.tb_clr && $past(adc_enabled))
    else $error("conversion without enable");

  // compare high sets the pin on match
  cmp_high_a: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    (match && !s_r.match_d && mode == CCPU_M_CMPHI) |=> s_r.pin_out)
    else $error("compare high missed");

  // zero control write forces output low
  off_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    (wr && widx == CCPU_IDX_CTRL && wb[3:0] == CCPU_M_OFF) |=> !s_r.pin_out)
    else $error("output not forced low");

  // 16th edge capture needs full prescale count
  pre_sixteen_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    (mode == CCPU_M_RISE16 && cap_evt) |-> (s_r.pre == CCPU_PRE_16))
    else $error("early 16th edge capture");

  // pwm duty latched at wrap
  pwm_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
    (cls == CCPU_PWM && period_timer_wrap) |=>
      (s_r.val_hi == $past(s_r.val_lo)))
    else $error("duty not latched");

  // compare low clears the pin on match
  cmp_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    (match && !s_r.match_d && mode == CCPU_M_CMPLO) |=> !s_r.pin_out)
    else $error("compare low missed");

  // interrupt-only compare leaves the pin alone
  cmp_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    (match && !s_r.match_d && mode == CCPU_M_CMPSW && !wr) |=>
      $stable(s_r.pin_out))
    else $error("pin moved in interrupt mode");

  // every first cycle of a match raises the flag
  cmp_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    (match && !s_r.match_d) |=> s_r.flag)
    else $error("match did not flag");

  // no conversion start while the converter is disabled
  adc_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    !adc_enabled |=> !s_r.adc_go)
    else $error("conversion while disabled");

  // timebase reset is a single-cycle pulse
  tb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    s_r.tb_clr |=> !s_r.tb_clr)
    else $error("timebase reset too long");

  // prescale switch inside capture keeps the count
  pre_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    (cls == CCPU_CAP && wr && widx == CCPU_IDX_CTRL && !rise &&
     mode_class(wb[3:0]) == CCPU_CAP) |=> $stable(s_r.pre))
    else $error("prescaler lost on switch");

  // pwm period start drives the pin high for a non-zero duty
  pwm_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
    (cls == CCPU_PWM && period_timer_wrap && !wr &&
     {s_r.val_lo, s_r.ctrl[CCPU_DUTY_LSB +: 2]} != 10'h000) |=> s_r.pin_out)
    else $error("pwm period did not set pin");

  // duty match clears the pin
  pwm_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
    (cls == CCPU_PWM && !period_timer_wrap &&
     {period_timer_count, period_timer_sub} == {s_r.val_hi, s_r.duty_lo})
      |=> !s_r.pin_out)
    else $error("pwm duty match missed");

  // high byte is read-only while in pwm
  hi_ro_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    (cls == CCPU_PWM && !period_timer_wrap && wr &&
     widx == CCPU_IDX_VAL_HI) |=> $stable(s_r.val_hi))
    else $error("pwm high byte written");

  // 4th edge capture only when the count reaches three
  pre_four_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    (mode == CCPU_M_RISE4 && cap_evt) |-> (s_r.pre[1:0] == CCPU_PRE_4[1:0]))
    else $error("early 4th edge capture");

  // falling edge mode captures on falls only
  fall_evt_a: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    (mode == CCPU_M_FALL && cap_evt) |-> (!s_r.pin_s2 && s_r.pin_d))
    else $error("capture on wrong edge");

  // a capture beats a software clear in the same cycle
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    (cls == CCPU_CAP && cap_evt && wr && widx == CCPU_IDX_IRQ) |=> s_r.flag)
    else $error("clear beat capture");

endmodule

// File: tb/ccpu_pin_src.sv
// pin source model: an outside signal driving the unit's capture pin
// assumes one bench process calls pulse, on pclk
`timescale 1ns/1ps

module ccpu_pin_src (
  // clock
  input  wire logic pclk,
  // pin level
  output logic      pin_in
);
  initial pin_in = 1'b0;

  // one high pulse; each level held 6 cycles so the 2-flop sync sees it
  task automatic pulse();
    @(posedge pclk);
    pin_in <= 1'b1;
    repeat (6) @(posedge pclk);
    pin_in <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
endmodule

// File: tb/test_capture_compare_pwm_unit.sv
// self-checking bench for the capture/compare/pwm unit
// assumes ccpu_pkg, ccpu_unit and ccpu_pin_src are compiled first
`timescale 1ns/1ps

module test_capture_compare_pwm_unit;
  import ccpu_pkg::*;
  logic          pclk, presetn, adc_en, route, pin_dir, pt_wrap, slv;
  logic          pin_in, tb_rst, adc_go, pin2, pin3, drives, flag, irq;
  logic          seen_tr, seen_adc;
  logic [15:0]   tbc, v, got;
  logic [9:0]    pt;
  logic [3:0]    m;
  logic [31:0]   rd, hi_cnt;
  ccpu_apb_req_t req;
  ccpu_apb_rsp_t rsp;
  int            err_total, num_checks;
  logic [3:0]    cm [4] = '{4'h8, 4'hA, 4'h9, 4'hB};

  ccpu_unit dut_u (
    .pclk               (pclk),
    .presetn            (presetn),
    .apb_req            (req),
    .apb_rsp            (rsp),
    .timebase_count     (tbc),
    .period_timer_count (pt[9:2]),
    .period_timer_sub   (pt[1:0]),
    .period_timer_wrap  (pt_wrap),
    .adc_enabled        (adc_en),
    .timebase_reset     (tb_rst),
    .adc_start          (adc_go),
    .pin_route_select   (route),
    .pin_in             (pin_in),
    .port_pin_is_output (pin_dir),
    .port_pin_two_out   (pin2),
    .port_pin_three_out (pin3),
    .unit_drives_pin    (drives),
    .unit_irq_flag      (flag),
    .unit_irq_request   (irq)
  );

  ccpu_pin_src src_u (
    .pclk   (pclk),
    .pin_in (pin_in)
  );

  // *****
  // clock, period timer, pulse catchers
  // *****
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // period timer runs free, wrap pulses once per 1024 cycles
  always @(posedge pclk)
  begin
    pt <= pt + 10'h001;
    pt_wrap <= (pt == 10'h3FF);
  end

  // one-cycle pulses are latched so a later check cannot miss them
  always @(posedge pclk)
  begin
    if (tb_rst === 1'b1)
      seen_tr = 1'b1;
    if (adc_go === 1'b1)
      seen_adc = 1'b1;
  end

  // *****
  // tasks
  // *****
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] gt);
    num_checks++;
    if (gt !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, gt);
      err_total++;
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(logic wr, logic [7:0] idx, logic [7:0] wd);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr,
             paddr: {2'b00, idx, 2'b00}, pwdata: {24'h000000, wd}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    slv = rsp.pslverr;
    req <= '0;
  endtask

  task automatic rd_val(output logic [15:0] val);
    apb(1'b0, CCPU_IDX_VAL_LO, 8'h00);
    val[7:0] = rd[7:0];
    apb(1'b0, CCPU_IDX_VAL_HI, 8'h00);
    val[15:8] = rd[7:0];
  endtask

  function automatic int edges(logic [3:0] mm);
    return (mm == CCPU_M_RISE4) ? 4 : (mm == CCPU_M_RISE16) ? 16 : 1;
  endfunction

  // duty as a 10-bit count: low byte, then control bits 5:4
  function automatic logic [31:0] duty_of(logic [7:0] lo, logic [7:0] c);
    return {22'h0, lo, c[5:4]};
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far beyond the few thousand cycles the run needs
  initial
  begin
    #500000;
    err_total++;
    final_report();
  end

  // *****
  // main sequence
  // *****
  initial
  begin
    req = '0;
    presetn = 1'b0;
    adc_en = 1'b0;
    route = 1'b0;
    pin_dir = 1'b0;
    tbc = 16'h0000;
    pt = '0;
    pt_wrap = 1'b0;
    seen_tr = 1'b0;
    seen_adc = 1'b0;
    err_total = 0;
    num_checks = 0;
    void'($urandom(32'h641E862F));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CCPU_IDX_CTRL, 8'h00);
    chk("ctrl reset", 32'h00000000, rd);
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped err", 32'h00000001, {31'h0, slv});
    // every capture mode, two rounds without reading: second overwrites
    for (int i = 0; i < 4; i++)
    begin
      m = CCPU_M_FALL + 4'(i);
      apb(1'b1, CCPU_IDX_CTRL, 8'h00);
      apb(1'b1, CCPU_IDX_CTRL, {4'h0, m});
      repeat (2)
      begin
        apb(1'b1, CCPU_IDX_IRQ, 8'h00);
        for (int k = 1; k <= edges(m); k++)
        begin
          tbc <= 16'($urandom);
          src_u.pulse();
          apb(1'b0, CCPU_IDX_IRQ, 8'h00);
          chk("cap flag", {29'h0, k == edges(m), 2'b00}, rd & 32'h4);
        end
      end
      rd_val(got);
      chk("cap value", {16'h0, tbc}, {16'h0, got});
      apb(1'b0, CCPU_IDX_IRQ, 8'h00);
      chk("flag sticky", 32'h00000004, rd & 32'h4);
    end
    apb(1'b1, CCPU_IDX_IEN, 8'h04);
    @(posedge pclk);
    chk("irq request", 32'h00000001, {31'h0, irq});
    src_u.pulse();
    apb(1'b1, CCPU_IDX_CTRL, {4'h0, CCPU_M_CMPSW});
    apb(1'b0, CCPU_IDX_STATUS, 8'h00);
    chk("prescaler clear", 32'h00000000, rd & 32'h1E);
    // compare modes with matches; pin now owned by the unit
    route <= 1'($urandom);
    pin_dir <= 1'b1;
    adc_en <= 1'($urandom);
    v = 16'($urandom);
    tbc <= ~v;
    apb(1'b1, CCPU_IDX_VAL_LO, v[7:0]);
    apb(1'b1, CCPU_IDX_VAL_HI, v[15:8]);
    rd_val(got);
    chk("value pair", {16'h0, v}, {16'h0, got});
    for (int i = 0; i < 4; i++)
    begin
      tbc <= ~v;
      apb(1'b1, CCPU_IDX_CTRL, {4'h0, cm[i]});
      apb(1'b1, CCPU_IDX_IRQ, 8'h00);
      seen_tr = 1'b0;
      seen_adc = 1'b0;
      tbc <= v;
      repeat (4) @(posedge pclk);
      chk("match flag", 32'h00000001, {31'h0, flag});
      chk("pin level", {31'h0, i < 2}, {31'h0, route ? pin3 : pin2});
      chk("other pin", 32'h0, {31'h0, route ? pin2 : pin3});
      chk("drives pin", 32'h00000001, {31'h0, drives});
      chk("tb reset", {31'h0, cm[i] == 4'hB}, {31'h0, seen_tr});
      chk("adc start", {31'h0, cm[i] == 4'hB && adc_en},
          {31'h0, seen_adc});
    end
    // raise the latch first so the zero write has something to clear
    tbc <= ~v;
    apb(1'b1, CCPU_IDX_CTRL, {4'h0, CCPU_M_CMPHI});
    tbc <= v;
    repeat (2) @(posedge pclk);
    chk("latch on", 32'h1, {31'h0, route ? pin3 : pin2});
    apb(1'b1, CCPU_IDX_CTRL, 8'h00);
    @(posedge pclk);
    chk("latch off", 32'h0, {31'h0, route ? pin3 : pin2});
    // pwm: duty copied at period wrap, high byte not writable
    apb(1'b1, CCPU_IDX_VAL_LO, 8'h5A);
    apb(1'b1, CCPU_IDX_CTRL, 8'h1C);
    apb(1'b1, CCPU_IDX_VAL_HI, 8'hC3);
    repeat (1100) @(posedge pclk);
    apb(1'b0, CCPU_IDX_VAL_HI, 8'h00);
    chk("duty latch", 32'h0000005A, rd);
    apb(1'b0, CCPU_IDX_CTRL, 8'h00);
    chk("duty low", 32'h0000001C, rd);
    // one full 1024-cycle period: high for the duty count
    hi_cnt = 32'h00000000;
    repeat (1024)
    begin
      @(posedge pclk);
      hi_cnt += {31'h0, route ? pin3 : pin2};
    end
    chk("pwm high time", duty_of(8'h5A, 8'h1C), hi_cnt);
    final_report();
  end
endmodule
